// ===== include/dcs_pkg.sv
// constants, codes and helpers shared by the disk command/status block
package dcs_pkg;
  localparam int DW        = 12;   // interface register width
  localparam int AW        = 8;    // sector buffer address width
  localparam int CW        = 9;    // word counter width
  localparam int BUF_DEPTH = 256;
  localparam int SYNC_W    = 5;

  // command word fields (vector index = 11 - printed bit number)
  localparam int CMD_FUNC_LSB = 1;
  localparam int CMD_DRIVE    = 4;
  localparam int CMD_WLEN     = 6;
  localparam int CMD_DENS     = 7;
  localparam int AC_INT_EN    = 0;

  // error/status word fields
  localparam int ST_READY = 7;
  localparam int ST_DEL   = 6;
  localparam int ST_MDENS = 5;
  localparam int ST_DERR  = 4;
  localparam int ST_DUAL  = 3;
  localparam int ST_INIT  = 2;
  localparam int ST_PAR   = 1;
  localparam int ST_CRC   = 0;

  localparam logic [DW-1:0] STATUS_RESET = 12'h000;
  localparam logic [DW-1:0] CMD_RESET    = 12'h000;
  localparam logic [DW-1:0] BYTE_MASK    = 12'h0ff;

  // buffer word counts
  localparam logic [CW-1:0] WORDS_SD8  = 9'h080;
  localparam logic [CW-1:0] WORDS_SD12 = 9'h040;
  localparam logic [CW-1:0] WORDS_DD8  = 9'h100;
  localparam logic [CW-1:0] WORDS_DD12 = 9'h080;

  // initialise sequence length
  localparam int CLK_PERIOD_NS = 25;
  localparam int INIT_TIME_NS  = 1000;
  localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    FN_FILL   = 3'h0,
    FN_EMPTY  = 3'h1,
    FN_WRITE  = 3'h2,
    FN_READ   = 3'h3,
    FN_DENS   = 3'h4,
    FN_STATUS = 3'h5,
    FN_WDEL   = 3'h6,
    FN_ERRREG = 3'h7
  } dcs_func_t;

  // number of words moved by fill or empty
  function automatic logic [CW-1:0] word_count(input logic dual, input logic dd,
                                               input logic eight);
    if (dual && dd) word_count = eight ? WORDS_DD8 : WORDS_DD12;
    else            word_count = eight ? WORDS_SD8 : WORDS_SD12;
  endfunction : word_count
endpackage : dcs_pkg

// ===== include/dcs_buf_if.sv
// sector buffer port between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface dcs_buf_if;
  logic [dcs_pkg::AW-1:0] addr;
  logic                   we;
  logic [dcs_pkg::DW-1:0] wdata;
  logic [dcs_pkg::DW-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface : dcs_buf_if
`default_nettype wire

// ===== rtl/dcs_sector_ram.sv
// sector buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module dcs_sector_ram #(
  parameter int DEPTH = dcs_pkg::BUF_DEPTH
) (
  input  wire logic ref_clk_in,
  dcs_buf_if.mem    buf_port
);
  logic [dcs_pkg::DW-1:0] mem [DEPTH];

  // no reset on the array; read data registered every edge
  always_ff @(posedge ref_clk_in) begin
    if (buf_port.we) begin
      mem[buf_port.addr] <= buf_port.wdata;
    end
    buf_port.rdata <= mem[buf_port.addr];
  end
endmodule : dcs_sector_ram
`default_nettype wire

// ===== rtl/dcs_status_word.sv
// error/status word bits and their mode-dependent view
`timescale 1ns/1ps
`default_nettype none
module dcs_status_word (
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   dual_mode_in,
  input  wire logic                   clear_in,
  input  wire logic                   init_done_in,
  input  wire logic                   refresh_in,
  input  wire logic                   par_in,
  input  wire logic                   derr_in,
  input  wire logic                   del_in,
  input  wire logic                   crc_in,
  input  wire logic                   unit_ready_in,
  input  wire logic                   media_density_in,
  input  wire logic                   cmd_density_in,
  output logic [dcs_pkg::DW-1:0]      word_out
);
  logic unit_ready, deleted_mark_seen, media_density, density_mismatch;
  logic init_complete, command_shift_error, crc_error;

  // clear first, events after it so a same-cycle event survives
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      unit_ready          <= 1'b0;
      deleted_mark_seen   <= 1'b0;
      media_density       <= 1'b0;
      density_mismatch    <= 1'b0;
      init_complete       <= 1'b0;
      command_shift_error <= 1'b0;
      crc_error           <= 1'b0;
    end else begin
      if (clear_in) begin
        unit_ready          <= 1'b0;
        deleted_mark_seen   <= 1'b0;
        media_density       <= 1'b0;
        density_mismatch    <= 1'b0;
        init_complete       <= 1'b0;
        command_shift_error <= 1'b0;
        crc_error           <= 1'b0;
      end
      if (init_done_in || refresh_in) begin
        unit_ready <= unit_ready_in;
      end
      if (init_done_in) init_complete <= 1'b1;
      // read status drops init done and refreshes density
      if (refresh_in) begin
        init_complete <= 1'b0;
        media_density <= media_density_in;
        if (dual_mode_in && media_density_in != cmd_density_in) density_mismatch <= 1'b1;
      end
      if (del_in) deleted_mark_seen <= 1'b1;
      if (par_in) command_shift_error <= 1'b1;
      if (derr_in) density_mismatch <= 1'b1;
      if (crc_in) crc_error <= 1'b1;
    end
  end

  // mode 1 hides bits 6-8; mode 2 view
  always_comb begin
    word_out                       = dcs_pkg::STATUS_RESET;
    word_out[dcs_pkg::ST_READY]    = unit_ready;
    word_out[dcs_pkg::ST_DEL]      = deleted_mark_seen;
    word_out[dcs_pkg::ST_MDENS]    = dual_mode_in & media_density;
    word_out[dcs_pkg::ST_DERR]     = dual_mode_in & density_mismatch;
    word_out[dcs_pkg::ST_DUAL]     = dual_mode_in;
    word_out[dcs_pkg::ST_INIT]     = init_complete;
    word_out[dcs_pkg::ST_PAR]      = command_shift_error;
    word_out[dcs_pkg::ST_CRC]      = crc_error;
  end
endmodule : dcs_status_word
`default_nettype wire

// ===== rtl/dcs_ctrl.sv
// disk controller function protocol: command, buffer loops, write sector
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl #(
  parameter int INIT_CYCLES = dcs_pkg::INIT_CYCLES
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic [dcs_pkg::DW-1:0] ac_in,
  input  wire logic                   load_command_op_in,
  input  wire logic                   transfer_word_op_in,
  input  wire logic                   skip_on_request_op_in,
  input  wire logic                   skip_on_error_op_in,
  input  wire logic                   skip_on_done_op_in,
  input  wire logic                   int_enable_op_in,
  input  wire logic                   init_op_in,
  input  wire logic                   clear_flags_op_in,
  input  wire logic                   cmd_parity_error_in,
  input  wire logic                   dual_mode_in,
  input  wire logic                   unit_ready_in,
  input  wire logic                   media_density_in,
  input  wire logic                   write_done_in,
  input  wire logic                   crc_error_in,
  output logic [dcs_pkg::DW-1:0]      ac_out,
  output logic                        skip_out,
  output logic                        transfer_request_out,
  output logic                        done_out,
  output logic                        error_out,
  output logic                        irq_out,
  output logic                        drive_select_out,
  output logic                        write_start_out,
  output logic                        write_deleted_out,
  output logic [7:0]                  write_track_out,
  output logic [7:0]                  write_sector_out
);
  typedef enum logic [11:0] {
    ST_IDLE       = 12'h001,
    ST_INIT       = 12'h002,
    ST_FILL_WAIT  = 12'h004,
    ST_EMPTY_RD   = 12'h008,
    ST_EMPTY_REQ  = 12'h010,
    ST_EMPTY_WAIT = 12'h020,
    ST_WS_SEC     = 12'h040,
    ST_WS_TRK     = 12'h080,
    ST_WS_CHECK   = 12'h100,
    ST_WS_BUSY    = 12'h200,
    ST_FINISH     = 12'h400,
    ST_SPARE      = 12'h800
  } dcs_state_t;

  dcs_state_t state, next_state;
  logic [dcs_pkg::DW-1:0]     cmd, iface, status_word;
  logic [dcs_pkg::CW-1:0]     cnt, words;
  logic [15:0]                init_cnt;
  logic [dcs_pkg::SYNC_W-1:0] sync1, sync2;
  logic                       wd_q, wd_rise, dual_s, ready_s, dens_s, crc_s;
  logic                       tr, done, err, int_en, irq_pend, err_pend;
  logic                       eight, init_req, lcd_take;
  logic                       tr_set, fin_err, cnt_clr, cnt_inc, buf_we, cap_sec, cap_trk;
  logic                       wr_go, st_clr, st_init, st_ref, st_par, st_derr, st_del;
  dcs_pkg::dcs_func_t         func;
  dcs_buf_if                  buf_bus ();

  // drive-side pins cross in through two flops
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
      wd_q  <= 1'b0;
    end else begin
      sync1 <= {crc_error_in, write_done_in, media_density_in, unit_ready_in, dual_mode_in};
      sync2 <= sync1;
      wd_q  <= sync2[3];
    end
  end
  assign dual_s  = sync2[0];
  assign ready_s = sync2[1];
  assign dens_s  = sync2[2];
  assign wd_rise = sync2[3] & ~wd_q;
  assign crc_s   = sync2[4] & ~st_clr;

  assign eight = cmd[dcs_pkg::CMD_WLEN];
  assign words    = dcs_pkg::word_count(dual_s, cmd[dcs_pkg::CMD_DENS], eight);
  assign func     = dcs_pkg::dcs_func_t'(ac_in[dcs_pkg::CMD_FUNC_LSB +: 3]);
  assign init_req = init_op_in | clear_flags_op_in;
  assign lcd_take = load_command_op_in & (state == ST_IDLE);

  // sequencing of every function
  always_comb begin
    next_state = state;
    tr_set  = 1'b0;
    fin_err = 1'b0;
    cnt_clr = 1'b0;
    cnt_inc = 1'b0;
    buf_we  = 1'b0;
    cap_sec = 1'b0;
    cap_trk = 1'b0;
    wr_go   = 1'b0;
    st_clr  = 1'b0;
    st_init = 1'b0;
    st_ref  = 1'b0;
    st_par  = 1'b0;
    st_derr = 1'b0;
    st_del  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (lcd_take) begin
          cnt_clr = 1'b1;
          if (cmd_parity_error_in && !dual_s) begin
            st_par     = 1'b1;
            fin_err    = 1'b1;
            next_state = ST_FINISH;
          end else begin
            st_par = cmd_parity_error_in;
            case (func)
              dcs_pkg::FN_FILL: begin
                tr_set     = 1'b1;
                next_state = ST_FILL_WAIT;
              end
              dcs_pkg::FN_EMPTY: next_state = ST_EMPTY_RD;
              dcs_pkg::FN_WRITE, dcs_pkg::FN_WDEL: begin
                st_clr     = 1'b1;
                st_del     = (func == dcs_pkg::FN_WDEL);
                tr_set     = 1'b1;
                next_state = ST_WS_SEC;
              end
              dcs_pkg::FN_STATUS: begin
                st_ref     = 1'b1;
                next_state = ST_FINISH;
              end
              default: next_state = ST_FINISH;
            endcase
          end
        end
      end
      ST_INIT: begin
        if (init_cnt == 16'(INIT_CYCLES - 1)) begin
          st_init    = 1'b1;
          next_state = ST_FINISH;
        end
      end
      ST_FILL_WAIT: begin
        if (transfer_word_op_in) begin
          buf_we  = 1'b1;
          cnt_inc = 1'b1;
          if (cnt == words - 9'h001) next_state = ST_FINISH;
          else tr_set = 1'b1;
        end
      end
      ST_EMPTY_RD: next_state = ST_EMPTY_REQ;
      ST_EMPTY_REQ: begin
        tr_set     = 1'b1;
        next_state = ST_EMPTY_WAIT;
      end
      ST_EMPTY_WAIT: begin
        if (transfer_word_op_in) begin
          cnt_inc = 1'b1;
          next_state = (cnt == words - 9'h001) ? ST_FINISH : ST_EMPTY_RD;
        end
      end
      ST_WS_SEC: begin
        if (transfer_word_op_in) begin
          cap_sec    = 1'b1;
          tr_set     = 1'b1;
          next_state = ST_WS_TRK;
        end
      end
      ST_WS_TRK: begin
        if (transfer_word_op_in) begin
          cap_trk    = 1'b1;
          next_state = ST_WS_CHECK;
        end
      end
      ST_WS_CHECK: begin
        if (dual_s ? (dens_s != cmd[dcs_pkg::CMD_DENS]) : dens_s) begin
          st_derr    = 1'b1;
          fin_err    = 1'b1;
          next_state = ST_FINISH;
        end else begin
          wr_go      = 1'b1;
          next_state = ST_WS_BUSY;
        end
      end
      ST_WS_BUSY: if (wd_rise) next_state = ST_FINISH;
      ST_FINISH: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (crc_s && state != ST_INIT) begin
      fin_err    = 1'b1;
      next_state = ST_FINISH;
    end
    // programmed init overrides anything in flight
    if (init_req) begin
      st_clr     = 1'b1;
      tr_set     = 1'b0;
      next_state = ST_INIT;
    end
  end

  // state register; power-up runs the init sequence
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) state <= ST_INIT;
    else             state <= next_state;
  end

  // init timer and word counter
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      init_cnt <= 16'h0000;
      cnt      <= 9'h000;
    end else begin
      init_cnt <= (state == ST_INIT && !init_req) ? init_cnt + 16'h0001 : 16'h0000;
      if (cnt_clr)      cnt <= 9'h000;
      else if (cnt_inc) cnt <= cnt + 9'h001;
    end
  end

  // command latch and write-sector parameters
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd              <= dcs_pkg::CMD_RESET;
      write_sector_out <= 8'h00;
      write_track_out  <= 8'h00;
      write_start_out  <= 1'b0;
    end else begin
      // init addresses drive 0
      if (init_req)      cmd <= dcs_pkg::CMD_RESET;
      else if (lcd_take) cmd <= ac_in;
      if (cap_sec) write_sector_out <= ac_in[7:0];
      if (cap_trk) write_track_out  <= ac_in[7:0];
      write_start_out <= wr_go;
    end
  end
  assign drive_select_out  = cmd[dcs_pkg::CMD_DRIVE];
  assign write_deleted_out = (cmd[dcs_pkg::CMD_FUNC_LSB +: 3] == dcs_pkg::FN_WDEL);

  // interface register and data returned to the host
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      iface  <= dcs_pkg::STATUS_RESET;
      ac_out <= dcs_pkg::STATUS_RESET;
    end else begin
      if (state == ST_FINISH)        iface <= status_word;
      else if (state == ST_EMPTY_REQ) iface <= eight ? (buf_bus.rdata & dcs_pkg::BYTE_MASK)
                                                     : buf_bus.rdata;
      else if (lcd_take)             iface <= ac_in;
      // after done the register holds status
      if (transfer_word_op_in && (done || state == ST_EMPTY_WAIT)) ac_out <= iface;
    end
  end

  // host flags; a set in the clearing cycle wins, except that init also suppresses a request-flag set
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tr       <= 1'b0;
      done     <= 1'b0;
      err      <= 1'b0;
      err_pend <= 1'b0;
    end else begin
      tr       <= tr_set | (tr & ~skip_on_request_op_in & ~init_req);
      done     <= (state == ST_FINISH) | (done & ~skip_on_done_op_in & ~clear_flags_op_in);
      err      <= (state == ST_FINISH && err_pend) |
                  (err & ~skip_on_error_op_in & ~clear_flags_op_in);
      err_pend <= fin_err | (err_pend & (state != ST_FINISH));
    end
  end
  assign skip_out = (skip_on_request_op_in & tr) | (skip_on_done_op_in & done) |
                    (skip_on_error_op_in & err);

  // interrupt on done rising edge while enabled
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_en   <= 1'b0;
      irq_pend <= 1'b0;
    end else begin
      if (init_req)              int_en <= 1'b0;
      else if (int_enable_op_in) int_en <= ac_in[dcs_pkg::AC_INT_EN];
      irq_pend <= (state == ST_FINISH && !done) |
                  (irq_pend & ~skip_on_done_op_in & ~clear_flags_op_in);
    end
  end
  assign irq_out              = int_en & irq_pend;
  assign transfer_request_out = tr;
  assign done_out             = done;
  assign error_out            = err;

  assign buf_bus.we    = buf_we;
  assign buf_bus.addr  = cnt[dcs_pkg::AW-1:0];
  assign buf_bus.wdata = eight ? (ac_in & dcs_pkg::BYTE_MASK) : ac_in;

  dcs_sector_ram #(
    .DEPTH (dcs_pkg::BUF_DEPTH)
  ) u_ram (
    .ref_clk_in (ref_clk_in),
    .buf_port   (buf_bus.mem)
  );

  dcs_status_word u_status (
    .ref_clk_in       (ref_clk_in),
    .reset_n_in       (reset_n_in),
    .dual_mode_in     (dual_s),
    .clear_in         (st_clr),
    .init_done_in     (st_init),
    .refresh_in       (st_ref),
    .par_in           (st_par),
    .derr_in          (st_derr),
    .del_in           (st_del),
    .crc_in           (crc_s),
    .unit_ready_in    (ready_s),
    .media_density_in (dens_s),
    // status read compares against the density bit of the command now being loaded
    .cmd_density_in   (lcd_take ? ac_in[dcs_pkg::CMD_DENS] : cmd[dcs_pkg::CMD_DENS]),
    .word_out         (status_word)
  );
endmodule : dcs_ctrl
`default_nettype wire

// ===== dv/dcs_ctrl_assertions.sv
// port-level checks for the disk controller
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_assertions (
  input wire logic                   ref_clk_in,
  input wire logic                   reset_n_in,
  input wire logic                   transfer_word_op_in,
  input wire logic                   skip_on_request_op_in,
  input wire logic                   skip_on_done_op_in,
  input wire logic                   dual_mode_in,
  input wire logic [dcs_pkg::DW-1:0] ac_out,
  input wire logic                   skip_out,
  input wire logic                   transfer_request_out,
  input wire logic                   done_out,
  input wire logic                   error_out,
  input wire logic                   irq_out,
  input wire logic                   write_start_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // status read back after done
  sequence s_stat;
    transfer_word_op_in && done_out;
  endsequence
  property p_req_skip; skip_on_request_op_in |-> skip_out == transfer_request_out; endproperty
  a_req_skip: assert property (p_req_skip) else $error("request skip wrong");
  property p_req_clr; skip_on_request_op_in && transfer_request_out |=> !transfer_request_out;
  endproperty
  a_req_clr: assert property (p_req_clr) else $error("request not cleared");
  property p_done_skip; skip_on_done_op_in |-> skip_out == done_out; endproperty
  a_done_skip: assert property (p_done_skip) else $error("done skip wrong");
  property p_done_clr; skip_on_done_op_in && done_out |=> !done_out && !irq_out; endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");
  property p_err_done; $rose(error_out) |-> done_out; endproperty
  a_err_done: assert property (p_err_done) else $error("error without done");
  property p_irq; $rose(irq_out) |-> $rose(done_out); endproperty
  a_irq: assert property (p_irq) else $error("irq without done edge");
  property p_stat_hi; s_stat |=> ac_out[11:8] == 4'h0; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("unused status bits set");
  property p_mode1; s_stat ##0 !dual_mode_in |=> ac_out[5:3] == 3'h0; endproperty
  a_mode1: assert property (p_mode1) else $error("mode bits in single mode");
  property p_mode2; s_stat ##0 dual_mode_in |=> ac_out[3]; endproperty
  a_mode2: assert property (p_mode2) else $error("dual support bit clear");
  property p_done_req; $rose(done_out) |-> !transfer_request_out; endproperty
  a_done_req: assert property (p_done_req) else $error("request left at done");
  // main scenarios reached
  c_err: cover property ($rose(done_out) && error_out);
  c_wr: cover property (write_start_out);
  c_irq: cover property ($rose(irq_out));
endmodule : dcs_ctrl_assertions
bind dcs_ctrl dcs_ctrl_assertions u_chk (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .dual_mode_in(dual_mode_in),
  .transfer_word_op_in(transfer_word_op_in), .skip_on_request_op_in(skip_on_request_op_in),
  .skip_on_done_op_in(skip_on_done_op_in), .ac_out(ac_out), .skip_out(skip_out),
  .transfer_request_out(transfer_request_out), .done_out(done_out), .error_out(error_out),
  .irq_out(irq_out), .write_start_out(write_start_out));
`default_nettype wire

// ===== dv/dcs_host_model.sv
// host program model: one instruction strobe per op call; xfer polls the request skip, then transfers one word
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
  input  wire logic                   ref_clk_in,
  input  wire logic                   skip_in,
  input  wire logic                   done_in,
  input  wire logic [dcs_pkg::DW-1:0] data_in,
  output logic      [7:0]             op_out,
  output logic      [dcs_pkg::DW-1:0] ac_out
);
  logic                   skip;
  logic [dcs_pkg::DW-1:0] rd;
  int                     stalls = 0;   // requests never seen, or done while waiting
  initial begin
    op_out = 8'h00;
    ac_out = 12'h000;
  end
  // strobe held one full cycle, skip read before the edge
  task automatic op(input int k, input logic [dcs_pkg::DW-1:0] a);
    @(negedge ref_clk_in);
    op_out[k] = 1'b1;
    ac_out    = a;
    #1 skip   = skip_in;
    @(negedge ref_clk_in);
    op_out = 8'h00;
    rd     = data_in;
  endtask : op
  task automatic xfer(input logic [dcs_pkg::DW-1:0] a);
    int n;
    n    = 0;
    skip = 1'b0;
    while (skip !== 1'b1 && n < 200) begin
      op(2, a);
      n++;
    end
    if (skip !== 1'b1 || done_in === 1'b1) stalls++;
    op(1, a);
  endtask : xfer
endmodule : dcs_host_model
`default_nettype wire

// ===== dv/disk_ctrl_status_and_buffer_protocol_tb.sv
// self-checking bench for the disk controller protocol
`timescale 1ns/1ps
`default_nettype none
module disk_ctrl_status_and_buffer_protocol_tb;
  logic                   ref_clk_in = 1'b0;
  logic                   reset_n_in = 1'b0;
  logic [7:0]             op;
  logic [dcs_pkg::DW-1:0] ac, ac_o, st;
  logic                   par = 1'b0, dual = 1'b0, rdy = 1'b1, mden = 1'b0;
  logic                   wdone = 1'b0, crc = 1'b0, ie = 1'b0;
  logic                   skip, tr, done, err, irq, dsel, wst, wdel;
  logic [7:0]             trk, sec;
  logic [31:0]            rnd = 32'h1803;
  logic [dcs_pkg::DW-1:0] q[$];
  int                     fail_count = 0, tests_run = 0, cyc = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  dcs_ctrl #(.INIT_CYCLES(4)) dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .ac_in(ac), .load_command_op_in(op[0]), .transfer_word_op_in(op[1]),
    .skip_on_request_op_in(op[2]), .skip_on_error_op_in(op[3]), .skip_on_done_op_in(op[4]),
    .int_enable_op_in(op[5]), .init_op_in(op[6]), .clear_flags_op_in(op[7]),
    .cmd_parity_error_in(par), .dual_mode_in(dual), .unit_ready_in(rdy),
    .media_density_in(mden), .write_done_in(wdone), .crc_error_in(crc), .ac_out(ac_o),
    .skip_out(skip), .transfer_request_out(tr), .done_out(done), .error_out(err),
    .irq_out(irq), .drive_select_out(dsel), .write_start_out(wst),
    .write_deleted_out(wdel), .write_track_out(trk), .write_sector_out(sec));
  dcs_host_model host (.ref_clk_in(ref_clk_in), .skip_in(skip), .done_in(done),
    .data_in(ac_o), .op_out(op), .ac_out(ac));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // command word: function, word length, density
  function automatic logic [11:0] cmd(input logic [2:0] f, input logic e8, input logic dd);
    cmd      = 12'h000;
    cmd[3:1] = f;
    cmd[6]   = e8;
    cmd[7]   = dd;
  endfunction : cmd
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    fail_count += host.stalls;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // wait done, read status, clear done before next command
  task automatic fin;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("done", 12'h001, {11'h0, done});
    chk("irq", {11'h0, ie}, {11'h0, irq});
    host.op(1, 12'h000);
    st = host.rd;
    host.op(4, 12'h000);
  endtask : fin
  // fill then empty twice; buffer must survive the first empty
  task automatic buf_run(input logic e8, input logic dd, input int n);
    q.delete();
    host.op(0, cmd(3'h0, e8, dd));
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      q.push_back(e8 ? rnd[11:0] & dcs_pkg::BYTE_MASK : rnd[11:0]);
      if (i == n - 1) chk("early done", 12'h000, {11'h0, done});
      host.xfer(rnd[11:0]);
    end
    fin();
    for (int k = 0; k < 2; k++) begin
      host.op(0, cmd(3'h1, e8, dd));
      for (int i = 0; i < n; i++) begin
        host.xfer(12'h000);
        chk("empty word", q[i], host.rd);
      end
      fin();
    end
  endtask : buf_run
  // write sector: sector, then track, then density check; del picks deleted data on drive 1
  task automatic wr(input logic dd, input logic bad, input logic del);
    int          n;
    logic [11:0] c;
    n    = 0;
    rnd  = lfsr(rnd);
    c    = cmd(del ? 3'h6 : 3'h2, 1'b0, dd);
    c[4] = del;
    host.op(0, c);
    host.xfer(rnd[11:0]);
    host.xfer(rnd[23:12]);
    while (!bad && wst !== 1'b1 && n < 100) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (!bad) begin
      chk("write start", 12'h001, {11'h0, wst});
      chk("sector", {4'h0, rnd[7:0]}, {4'h0, sec});
      chk("track", {4'h0, rnd[19:12]}, {4'h0, trk});
      wdone = 1'b1;
    end
    fin();
    wdone = 1'b0;
    chk("write error", {11'h0, bad}, {11'h0, err});
    chk("deleted bit", {11'h0, del}, {11'h0, st[6]});
    chk("deleted out", {11'h0, del}, {11'h0, wdel});
    chk("drive", {11'h0, del}, {11'h0, dsel});
    host.op(3, 12'h000);
  endtask : wr
  // ceiling well above the few thousand cycles the run needs
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    fin();
    chk("init status", 12'h084, st);
    ie = 1'b1;
    host.op(5, 12'h001);
    buf_run(1'b0, 1'b0, 64);
    ie = 1'b0;
    host.op(5, 12'h000);
    buf_run(1'b1, 1'b0, 128);
    wr(1'b0, 1'b0, 1'b0);
    chk("write status", 12'h000, st & 12'h007);
    mden = 1'b1;
    wr(1'b0, 1'b1, 1'b1);
    par = 1'b1;
    host.op(0, cmd(3'h5, 1'b0, 1'b0));
    par = 1'b0;
    fin();
    chk("parity err", 12'h001, {11'h0, err});
    chk("parity bit", 12'h002, st & 12'h002);
    host.op(3, 12'h000);
    // drive crc fault while idle: function forced to end with error
    crc = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    crc = 1'b0;
    fin();
    chk("crc err", 12'h001, {11'h0, err});
    chk("crc bit", 12'h001, st & 12'h001);
    host.op(3, 12'h000);
    dual = 1'b1;
    host.op(6, 12'h000);
    fin();
    chk("dual init", 12'h00c, st & 12'h00c);
    buf_run(1'b0, 1'b1, 128);
    wr(1'b0, 1'b1, 1'b0);
    chk("dual density", 12'h018, st & 12'h038);
    // diskette density only refreshed by a status read
    host.op(0, cmd(3'h5, 1'b0, 1'b0));
    fin();
    chk("dual status", 12'h0b8, st & 12'h0bc);
    give_verdict();
  end
endmodule : disk_ctrl_status_and_buffer_protocol_tb
`default_nettype wire
